//--- design/link_status_cfg.svh
// link status register offsets, bit positions and timing counts
`ifndef LINK_STATUS_CFG_SVH
`define LINK_STATUS_CFG_SVH
`define LS_ADDR 8'h6C
`define LS_BIT_CLK 0
`define LS_BIT_CAL 1
`define LS_BIT_LOCK 2
`define LS_BIT_ALIGN 3
`define LS_BIT_PHASE_READJUST_FLAG 4
`define LS_BIT_IDLE 5
`define LS_BIT_LINK 6
`define LS_SYNC_MIN_FRAMES 4'h4
`endif

//--- design/link_status_pkg.sv
// types shared by the link status register
package link_status_pkg;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_SYNC = 2'b01,
    LINK_ILAS = 2'b10,
    LINK_DATA = 2'b11
  } link_state_t;
endpackage

//--- design/jesd_link_status_reg.sv
// status register of the serial link transmitter with its flag logic
`timescale 1ns/10ps
`include "link_status_cfg.svh"

module jesd_link_status_reg
  import link_status_pkg::*;
(
  input wire logic clk, // 50 MHz clock
  input wire logic reset_n, // async reset, active low
  input wire logic frame_tick, // one-cycle frame clock enable
  input wire logic lmfc_tick, // one-cycle multiframe clock enable
  input wire logic sync_n_pin, // SYNCb from receiver, active low
  input wire logic sysref_pin, // SYSREF input
  input wire logic sysref_detect_enable, // SYSREF detection enable
  input wire logic ilas_done, // alignment sequence fully sent
  input wire logic pll_locked, // PLL lock indication
  input wire logic cal_done, // calibration complete
  input wire logic sample_clock_active, // activity on sample_clock_input
  input wire logic [7:0] cfg_addr, // configuration port address
  input wire logic cfg_wr, // write strobe
  input wire logic cfg_rd, // read strobe
  input wire logic [7:0] cfg_wdata, // write data
  output logic [7:0] cfg_rdata, // read data
  output logic cfg_rvalid, // read data valid
  output logic link_up, // link established
  output logic sysref_phase_adjust // pulse: local clocks realigned
);

  // ****************************************
  // input synchronisers
  // ****************************************
  // bit 0 SYNCb, bit 1 SYSREF, bit 2 sample clock activity
  logic [2:0] pin_raw;
  logic [2:0] sync_meta_q, sync_meta_d;
  logic [2:0] sync_s_q, sync_s_d;

  assign pin_raw = {sample_clock_active, sysref_pin, sync_n_pin};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      // idle levels after reset: SYNCb high, others low
      localparam logic RST_VAL = (g == 0) ? 1'b1 : 1'b0;

      // two flops per pin before any logic reads it
      always_comb begin
        sync_meta_d[g] = pin_raw[g];
        sync_s_d[g] = sync_meta_q[g];
      end

      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          sync_meta_q[g] <= RST_VAL;
          sync_s_q[g] <= RST_VAL;
        end else begin
          sync_meta_q[g] <= sync_meta_d[g];
          sync_s_q[g] <= sync_s_d[g];
        end
      end
    end
  endgenerate

  // ****************************************
  // sysref edge detect
  // ****************************************
  // settled level of the cycle before
  logic sysref_prev_q, sysref_prev_d;

  always_comb begin
    sysref_prev_d = sync_s_q[1];
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sysref_prev_q <= 1'b0;
    end else begin
      sysref_prev_q <= sysref_prev_d;
    end
  end

  logic sync_req;
  logic sysref_rise;
  logic clk_ok;
  assign sync_req = ~sync_s_q[0];
  assign clk_ok = sync_s_q[2];
  assign sysref_rise = sync_s_q[1] & ~sysref_prev_q & sysref_detect_enable;

  // ****************************************
  // link state machine
  // ****************************************
  link_state_t state_q, state_d;
  logic [3:0] frame_cnt_q, frame_cnt_d;

  always_comb begin
    state_d = state_q;
    frame_cnt_d = frame_cnt_q;
    case (state_q)
      LINK_IDLE, LINK_DATA: begin
        // count frame clocks of SYNCb held low
        if (!sync_req) begin
          frame_cnt_d = 4'h0;
        end else if (frame_tick) begin
          if (frame_cnt_q + 4'h1 >= `LS_SYNC_MIN_FRAMES) begin
            state_d = LINK_SYNC;
            frame_cnt_d = 4'h0;
          end else begin
            frame_cnt_d = frame_cnt_q + 4'h1;
          end
        end
      end
      LINK_SYNC: begin
        // release of SYNCb on a multiframe boundary starts alignment
        if (!sync_req && lmfc_tick) begin
          state_d = LINK_ILAS;
        end
      end
      LINK_ILAS: begin
        if (sync_req) begin
          state_d = LINK_SYNC;
        end else if (ilas_done) begin
          state_d = LINK_DATA;
        end
      end
      default: begin
        state_d = LINK_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= LINK_IDLE;
      frame_cnt_q <= 4'h0;
    end else begin
      state_q <= state_d;
      frame_cnt_q <= frame_cnt_d;
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  // one decode serves both strobes so reads and writes never disagree
  function automatic logic status_hit(input logic [7:0] addr);
    return addr == `LS_ADDR;
  endfunction

  logic wr_hit;
  logic rd_hit;

  assign wr_hit = cfg_wr && status_hit(cfg_addr);
  assign rd_hit = cfg_rd && status_hit(cfg_addr);

  // ****************************************
  // mirrored status bits
  // ****************************************
  // read-only bits follow their sources one cycle late
  logic link_up_flag_q, link_up_flag_d;
  logic sync_idle_flag_q, sync_idle_flag_d;
  logic synth_lock_flag_q, synth_lock_flag_d;
  logic calibration_complete_flag_q, calibration_complete_flag_d;
  logic input_clock_detected_q, input_clock_detected_d;

  always_comb begin
    link_up_flag_d = (state_q == LINK_DATA) && !sync_req;
    // idle reflects the process, not the raw pin
    sync_idle_flag_d = (state_q == LINK_IDLE || state_q == LINK_DATA)
      && (frame_cnt_q == 4'h0);
    synth_lock_flag_d = pll_locked;
    calibration_complete_flag_d = cal_done;
    input_clock_detected_d = clk_ok;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_up_flag_q <= 1'b0;
      sync_idle_flag_q <= 1'b1;
      synth_lock_flag_q <= 1'b0;
      calibration_complete_flag_q <= 1'b0;
      input_clock_detected_q <= 1'b0;
    end else begin
      link_up_flag_q <= link_up_flag_d;
      sync_idle_flag_q <= sync_idle_flag_d;
      synth_lock_flag_q <= synth_lock_flag_d;
      calibration_complete_flag_q <= calibration_complete_flag_d;
      input_clock_detected_q <= input_clock_detected_d;
    end
  end

  // ****************************************
  // sysref flags
  // ****************************************
  logic phase_readjust_flag_q, phase_readjust_flag_d;
  logic sysref_processed_flag_q, sysref_processed_flag_d;
  // local clocks already derived from an earlier sysref
  logic aligned_q, aligned_d;
  // one-cycle pulse toward the outputs
  logic pulse_d;
  logic phase_off;

  // phase moves unless the edge lands on a multiframe boundary of an aligned clock
  assign phase_off = ~(aligned_q & lmfc_tick);

  always_comb begin
    phase_readjust_flag_d = phase_readjust_flag_q;
    sysref_processed_flag_d = sysref_processed_flag_q;
    aligned_d = aligned_q;
    pulse_d = 1'b0;
    // write-one clears; a zero leaves the flag alone
    if (wr_hit && cfg_wdata[`LS_BIT_PHASE_READJUST_FLAG]) begin
      phase_readjust_flag_d = 1'b0;
    end
    if (wr_hit && cfg_wdata[`LS_BIT_ALIGN]) begin
      sysref_processed_flag_d = 1'b0;
    end
    // events win over a same-cycle write-one clear
    if (sysref_rise) begin
      sysref_processed_flag_d = 1'b1;
      aligned_d = 1'b1;
      if (phase_off) begin
        phase_readjust_flag_d = 1'b1;
        pulse_d = 1'b1;
      end
    end
    // a lost sample clock leaves no alignment worth keeping
    if (!clk_ok) begin
      phase_readjust_flag_d = 1'b0;
      sysref_processed_flag_d = 1'b0;
      aligned_d = 1'b0;
      pulse_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_readjust_flag_q <= 1'b0;
      sysref_processed_flag_q <= 1'b0;
      aligned_q <= 1'b0;
    end else begin
      phase_readjust_flag_q <= phase_readjust_flag_d;
      sysref_processed_flag_q <= sysref_processed_flag_d;
      aligned_q <= aligned_d;
    end
  end

  // ****************************************
  // read port
  // ****************************************
  logic [7:0] rdata_d;
  logic rvalid_d;

  always_comb begin
    rdata_d = 8'h00;
    // every read answers, other addresses and bit 7 with zero
    rvalid_d = cfg_rd;
    if (rd_hit) begin
      rdata_d[`LS_BIT_LINK] = link_up_flag_q;
      rdata_d[`LS_BIT_IDLE] = sync_idle_flag_q;
      rdata_d[`LS_BIT_PHASE_READJUST_FLAG] = phase_readjust_flag_q;
      rdata_d[`LS_BIT_ALIGN] = sysref_processed_flag_q;
      rdata_d[`LS_BIT_LOCK] = synth_lock_flag_q;
      rdata_d[`LS_BIT_CAL] = calibration_complete_flag_q;
      rdata_d[`LS_BIT_CLK] = input_clock_detected_q;
    end
  end

  // ****************************************
  // registered outputs
  // ****************************************
  // link_up changes in the same cycle as the status bit it mirrors
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata <= 8'h00;
      cfg_rvalid <= 1'b0;
      link_up <= 1'b0;
      sysref_phase_adjust <= 1'b0;
    end else begin
      cfg_rdata <= rdata_d;
      cfg_rvalid <= rvalid_d;
      link_up <= link_up_flag_d;
      sysref_phase_adjust <= pulse_d;
    end
  end

endmodule

//--- dv/link_status_chk.sv
// port assertions of the link status register
`timescale 1ns/10ps
module link_status_chk (
  input wire logic clk, reset_n, sync_n_pin, sysref_detect_enable, ilas_done, // inputs
  input wire logic pll_locked, cal_done, sample_clock_active, cfg_rd, cfg_rvalid, // inputs, and the cfg_rvalid output
  input wire logic [7:0] cfg_addr, cfg_rdata, // config port
  input wire logic link_up, sysref_phase_adjust // outputs
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_rd; cfg_rd && cfg_addr == 8'h6C; endsequence
  property p_unmap; cfg_rd && cfg_addr != 8'h6C |=> cfg_rvalid && cfg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_pll; pll_locked [*4] ##0 s_rd |=> cfg_rdata[2]; endproperty
  a_pll: assert property (p_pll) else $error("lock bit");
  property p_cal; cal_done [*4] ##0 s_rd |=> cfg_rdata[1]; endproperty
  a_cal: assert property (p_cal) else $error("cal bit");
  property p_loss; (!sample_clock_active) [*5] ##0 s_rd |=> cfg_rdata[4:3] == 2'h0; endproperty
  a_loss: assert property (p_loss) else $error("flags kept");
  property p_gate; (!sysref_detect_enable) [*6] |-> !sysref_phase_adjust; endproperty
  a_gate: assert property (p_gate) else $error("adjust while off");
  property p_down; (!sync_n_pin) [*5] |-> !link_up; endproperty
  a_down: assert property (p_down) else $error("link in sync");
  property p_rise; $rose(link_up) |-> ilas_done || $past(ilas_done); endproperty
  a_rise: assert property (p_rise) else $error("link early");
  property p_idle; (!sync_n_pin) [*8] ##0 s_rd |=> cfg_rdata[6:5] == 2'h0; endproperty
  a_idle: assert property (p_idle) else $error("idle in sync");
  property p_adj; sysref_phase_adjust |-> $past(sysref_detect_enable); endproperty
  a_adj: assert property (p_adj) else $error("adjust without enable");
endmodule
bind jesd_link_status_reg link_status_chk chk (.*);

//--- dv/rx_partner.sv
// far-end receiver model: frame ticks, sync requests, alignment done
`timescale 1ns/10ps
module rx_partner (
  input wire logic clk, reset_n, sync_req, // clock, reset, resync request
  output logic frame_tick, lmfc_tick, sync_n_pin, ilas_done // toward the block
);
  logic [3:0] div_q;
  logic [2:0] low_q;
  assign frame_tick = div_q[1:0] == 2'h3;
  assign lmfc_tick = div_q == 4'hF;
  assign sync_n_pin = low_q == 3'h0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 4'h0;
      low_q <= 3'h0;
      ilas_done <= 1'h0;
    end else begin
      div_q <= div_q + 4'h1;
      if (low_q == 3'h0) low_q <= {2'h0, sync_req};
      else if (frame_tick) low_q <= (low_q == 3'h6) ? 3'h0 : low_q + 3'h1;
      ilas_done <= sync_n_pin && (ilas_done || lmfc_tick);
    end
  end
endmodule

//--- dv/jesd_link_status_reg_tb.sv
// self-checking bench of the link status register
`timescale 1ns/10ps
module jesd_link_status_reg_tb;
  logic clk = '0, reset_n = '0, sync_req = '0, sysref_pin = '0, sysref_detect_enable = '0;
  logic pll_locked = '0, cal_done = '0, sample_clock_active = '1, cfg_wr = '0, cfg_rd = '0;
  logic [7:0] cfg_addr = '0, cfg_wdata = '0, cfg_rdata, a;
  logic cfg_rvalid, link_up, sysref_phase_adjust, frame_tick, lmfc_tick, sync_n_pin, ilas_done;
  logic [15:0] exp_q[$], n;
  logic [31:0] seed = 32'hF5FE;
  int fails = 0, tests_run = 0, i;
  always #10 clk = ~clk;
  rx_partner rx (.*);
  jesd_link_status_reg uut (.*);
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic nxt();
    seed = xs(seed);
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] ad, d, m);
    tick(1);
    cfg_addr = ad;
    cfg_wdata = d;
    cfg_wr = w;
    cfg_rd = !w;
    if (!w) exp_q.push_back({m, d});
    tick(1);
    cfg_wr = 1'h0;
    cfg_rd = 1'h0;
  endtask
  task automatic chk(input logic [7:0] e, m, s);
    tests_run++;
    if (((s ^ e) & m) !== 8'h00) fails++;
    if (((s ^ e) & m) !== 8'h00) $display("Error cfg_rdata expected %h seen %h", e, s);
  endtask
  always @(negedge clk) begin
    if (cfg_rvalid === 1'h1) begin
      n = (exp_q.size() > 0) ? exp_q.pop_front() : 16'hFF5A;
      chk(n[7:0], n[15:8], cfg_rdata);
    end
  end
  task automatic close_out(input logic hung);
    if (hung) fails++;
    $display("compares %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    tick(10);
    reset_n = 1'h1;
    tick(6);
    nxt();
    a = (seed[7:0] == 8'h6C) ? 8'h6D : seed[7:0];
    acc(1'h0, a, 8'h00, 8'hFF);
    acc(1'h0, 8'h6C, 8'h21, 8'hFF);
    for (i = 0; i < 4; i++) begin
      nxt();
      pll_locked = seed[0];
      cal_done = seed[1];
      tick(5);
      acc(1'h0, 8'h6C, {5'h04, pll_locked, cal_done, 1'h1}, 8'hFF);
    end
    pll_locked = 1'h1;
    cal_done = 1'h1;
    sync_req = 1'h1;
    tick(1);
    sync_req = 1'h0;
    tick(8);
    acc(1'h0, 8'h6C, 8'h07, 8'hFF);
    for (i = 0; i < 400 && link_up !== 1'h1; i++) tick(1);
    if (link_up !== 1'h1) close_out(1'h1);
    tick(3);
    acc(1'h0, 8'h6C, 8'h67, 8'hFF);
    for (i = 0; i < 2; i++) begin
      sysref_detect_enable = i[0];
      sysref_pin = 1'h1;
      tick(4);
      sysref_pin = 1'h0;
      tick(6);
      acc(1'h0, 8'h6C, i ? 8'h7F : 8'h67, 8'hFF);
    end
    nxt();
    acc(1'h1, a, 8'h18, 8'h00);
    acc(1'h1, 8'h6C, seed[7:0] & 8'hE7, 8'h00);
    acc(1'h0, 8'h6C, 8'h7F, 8'hFF);
    acc(1'h1, 8'h6C, 8'h10, 8'h00);
    acc(1'h0, 8'h6C, 8'h6F, 8'hFF);
    acc(1'h1, 8'h6C, 8'h08, 8'h00);
    acc(1'h0, 8'h6C, 8'h67, 8'hFF);
    sysref_pin = 1'h1;
    tick(6);
    sample_clock_active = 1'h0;
    tick(6);
    acc(1'h0, 8'h6C, 8'h26, 8'hBF);
    tick(4);
    close_out(exp_q.size() != 0);
  end
endmodule
